// >>> ipmc_bscell.sv
// one boundary-scan cell: capture/shift stage and update hold stage
// assumes strobes are single clk pulses decoded from a test clock edge
module ipmc_bscell
  import ipmc_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic cap_en,
  input  wire logic shift_en,
  input  wire logic upd_en,
  input  wire logic par_in,
  input  wire logic scan_in,
  output logic      scan_out,
  output logic      hold_out
);

  ipmc_cell_t st_reg;
  ipmc_cell_t st_next;

  // capture, shift and update of the cell
  always_comb
  begin
    st_next = st_reg;
    if (cap_en)
      st_next.shift_bit = par_in;
    else if (shift_en)
      st_next.shift_bit = scan_in;
    if (upd_en)
      st_next.hold_bit = st_reg.shift_bit;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  assign scan_out = st_reg.shift_bit;
  assign hold_out = st_reg.hold_bit;

  chk_cell_preload_hold: assert property (@(posedge clk) disable iff (!rst_n)
    upd_en |=> (hold_out == $past(scan_out)) ##1 ($stable(hold_out) || $past(upd_en)))
    else $error("boundary cell did not hold preloaded value");
endmodule : ipmc_bscell

// >>> ipmc_host.sv
// programming host model: walks the test port state machine on its own slow clock
// assumes the block samples tck with its own clock; tck stands still between frames
module ipmc_host (
  output logic      tck,
  output logic      tms,
  output logic      tdi,
  input  wire logic tdo,
  input  wire logic tdo_oe_n
);
  timeunit 1ns;
  timeprecision 1ns;

  // clock idles low between frames
  initial
  begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end

  // one test clock; tdo is read just before the rise
  task automatic step(input logic m, input logic d, output logic q);
    tms = m;
    tdi = d;
    #400;
    q   = tdo_oe_n ? !tdo : tdo;  // undriven line reads as the inverse
    tck = 1'b1;
    #400;
    tck = 1'b0;
  endtask : step

  // scan from idle or reset, lsb first, then update and back to idle
  task automatic scan(input logic ir, input int n, input logic [15:0] din, output logic [15:0] dout);
    logic q;
    #13;
    step(1'b0, 1'b0, q);
    step(1'b1, 1'b0, q);
    if (ir)
      step(1'b1, 1'b0, q);
    step(1'b0, 1'b0, q);
    step(1'b0, 1'b0, q);
    dout = '0;
    for (int k = 0; k < n; k++)
    begin
      step(k == n - 1, din[k], q);
      dout[k] = q;
    end
    step(1'b1, 1'b0, q);
    step(1'b0, 1'b0, q);
    tdi = 1'b1;  // released line does not keep the last bit
  endtask : scan
endmodule : ipmc_host

// >>> ipmc_map.svh
// offsets, field positions, reset values and timing counts of the clamp block
// assumes inclusion by ipmc_pkg and the bench only
`ifndef IPMC_MAP_SVH
`define IPMC_MAP_SVH

// apb register byte offsets
`define IPMC_CTRL_OFF       12'h000
`define IPMC_STATUS_OFF     12'h004

// control register fields
`define IPMC_CTRL_MODE_LSB  0
`define IPMC_CTRL_MODE_MSB  1
`define IPMC_CTRL_RESET     2'h0

// programming modes held in the control register
`define IPMC_MODE_NORMAL    2'h0
`define IPMC_MODE_BG        2'h1
`define IPMC_MODE_CLAMP     2'h2

// status register fields
`define IPMC_ST_USER        0
`define IPMC_ST_BUSY        1
`define IPMC_ST_PENDING     2
`define IPMC_ST_FAIL        3
`define IPMC_ST_COPY        4
`define IPMC_ST_IR_LSB      8
`define IPMC_ST_IR_MSB      11

// test port instruction codes
`define IPMC_IR_EXTEST      4'h0
`define IPMC_IR_SAMPLE      4'h5
`define IPMC_IR_PROGRAM     4'h8
`define IPMC_IR_BYPASS      4'hF
`define IPMC_IR_CAPTURE     4'h1

// user pin count and boundary chain length (data and enable cell per pin)
`define IPMC_PINS           8
`define IPMC_CHAIN          16

// timing: clock period, power-up load delay and self reset length
`define IPMC_CLK_NS         100
`define IPMC_PWRUP_DELAY_US 100
`define IPMC_PWRUP_CYC      ((`IPMC_PWRUP_DELAY_US * 1000) / `IPMC_CLK_NS)
`define IPMC_USER_RST_CYC   4

`endif

// >>> ipmc_pkg.sv
// types shared by the clamp block modules
// assumes ipmc_map.svh in the include path
package ipmc_pkg;
  `include "ipmc_map.svh"

  // configuration sequencing states
  typedef enum logic [2:0] {
    CF_LOAD, CF_WAIT, CF_USER, CF_PROG, CF_BGPROG, CF_COPY, CF_RESET
  } ipmc_cfg_t;

  // test access port controller states
  typedef enum logic [3:0] {
    TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SH_DR, TAP_EX1_DR, TAP_PAU_DR, TAP_EX2_DR,
    TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR, TAP_SH_IR, TAP_EX1_IR, TAP_PAU_IR, TAP_EX2_IR, TAP_UPD_IR
  } ipmc_tap_t;

  // state of the top module, apart from the synchroniser and boundary cell registers
  typedef struct packed {
    ipmc_cfg_t   cfg;
    ipmc_tap_t   tap;
    logic        tck_prev;
    logic [3:0]  ir_shift;
    logic [3:0]  ir;
    logic        bypass;
    logic        tdo;
    logic        tdo_en;
    logic [15:0] cnt;
    logic [1:0]  mode;
    logic [1:0]  ctrl_mode;
    logic        pending;
    logic        fail;
    logic [31:0] prdata;
    logic        pslverr;
  } ipmc_state_t;

  // state of one boundary cell
  typedef struct packed {
    logic shift_bit;
    logic hold_bit;
  } ipmc_cell_t;
endpackage : ipmc_pkg

// >>> ipmc_sync.sv
// two flip-flop synchroniser for levels from outside the clock domain
// assumes clk is the block clock and inputs are asynchronous levels
module ipmc_sync
  import ipmc_pkg::*;
#(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } ipmc_sync_t;

  ipmc_sync_t st_reg;
  ipmc_sync_t st_next;

  // first stage feeds only the second
  always_comb
  begin
    st_next    = st_reg;
    st_next.s1 = d;
    st_next.s2 = st_reg.s1;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  assign q = st_reg.s2;
endmodule : ipmc_sync

// >>> ipmc_top.sv
// programming mode and pin clamp control with test port and apb registers
// assumes a flash controller and configuration loader on clk; test pins asynchronous
// Summary of operation
// - normal mode: copy flash only after programming
// - normal mode: pins tri-stated during program and copy
// - after copy, self reset then user mode
// - background mode: logic and pins stay live
// - background mode: no copy until power cycle
// - power-up: copy flash, user mode after delay
// - normal mode: tri-state with weak pull-up
// - clamp mode: each pin held at own state
// - clamp mode: pull-ups off throughout programming
// - preload instruction loads and holds cell values
// - extest drives pins from held cell values
// - clamp released after successful programming
module ipmc_top
  import ipmc_pkg::*;
(
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [11:0]           paddr,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  input  wire logic                  tck,
  input  wire logic                  tms,
  input  wire logic                  tdi,
  output logic                       tdo,
  output logic                       tdo_oe_n,
  output logic                       flash_prog_req,
  input  wire logic                  flash_prog_done,
  input  wire logic                  flash_prog_ok,
  output logic                       cfg_load_req,
  input  wire logic                  cfg_load_done,
  output logic                       core_rst_n,
  output logic                       user_mode,
  input  wire logic [`IPMC_PINS-1:0] core_out,
  input  wire logic [`IPMC_PINS-1:0] core_oe_n,
  output logic      [`IPMC_PINS-1:0] pin_out,
  output logic      [`IPMC_PINS-1:0] pin_oe_n,
  input  wire logic [`IPMC_PINS-1:0] pin_in,
  output logic                       pull_up_en
);

  ipmc_state_t st_reg;
  ipmc_state_t st_next;

  logic [2:0]              jtag_s;
  logic [`IPMC_PINS-1:0]   pin_s;
  logic                    tck_s;
  logic                    tms_s;
  logic                    tdi_s;
  logic                    rise;
  logic                    fall;
  logic                    bsr_sel;
  logic                    cap_en;
  logic                    sh_en;
  logic                    upd_en;
  logic [`IPMC_CHAIN:0]    chain;
  logic [`IPMC_CHAIN-1:0]  cell_hold;
  logic [`IPMC_CHAIN-1:0]  cell_par;
  logic [`IPMC_PINS-1:0]   cell_data;
  logic [`IPMC_PINS-1:0]   cell_en;
  logic                    extest;
  logic                    cfg_busy;
  logic                    clamp_act;
  logic                    wr_en;
  logic                    setup;

  // test port and pin levels cross into clk
  ipmc_sync #(.W(3)) u_jtag_sync (
    .clk   (clk),
    .rst_n (rst_n),
    .d     ({tck, tms, tdi}),
    .q     (jtag_s)
  );

  ipmc_sync #(.W(`IPMC_PINS)) u_pin_sync (
    .clk   (clk),
    .rst_n (rst_n),
    .d     (pin_in),
    .q     (pin_s)
  );

  assign tck_s = jtag_s[2];
  assign tms_s = jtag_s[1];
  assign tdi_s = jtag_s[0];

  // test clock edges found by clk
  assign rise = tck_s & ~st_reg.tck_prev;
  assign fall = ~tck_s & st_reg.tck_prev;

  // boundary chain strobes
  assign bsr_sel = (st_reg.ir == `IPMC_IR_EXTEST) || (st_reg.ir == `IPMC_IR_SAMPLE);
  assign cap_en  = rise && bsr_sel && (st_reg.tap == TAP_CAP_DR);
  assign sh_en   = rise && bsr_sel && (st_reg.tap == TAP_SH_DR);
  assign upd_en  = rise && bsr_sel && (st_reg.tap == TAP_UPD_DR);

  // cells: even index is pin data, odd index is pin drive enable
  assign chain[`IPMC_CHAIN] = tdi_s;
  genvar g;
  generate
    for (g = 0; g < `IPMC_PINS; g++)
    begin : g_pin
      assign cell_par[2*g]   = pin_s[g];
      assign cell_par[2*g+1] = ~core_oe_n[g];
      assign cell_data[g]    = cell_hold[2*g];
      assign cell_en[g]      = cell_hold[2*g+1];
    end
    for (g = 0; g < `IPMC_CHAIN; g++)
    begin : g_cell
      ipmc_bscell u_cell (
        .clk      (clk),
        .rst_n    (rst_n),
        .cap_en   (cap_en),
        .shift_en (sh_en),
        .upd_en   (upd_en),
        .par_in   (cell_par[g]),
        .scan_in  (chain[g+1]),
        .scan_out (chain[g]),
        .hold_out (cell_hold[g])
      );
    end
  endgenerate

  // tap controller next state
  function automatic ipmc_tap_t tap_step(input ipmc_tap_t s, input logic m);
    unique case (s)
      TAP_RESET:  tap_step = m ? TAP_RESET  : TAP_IDLE;
      TAP_IDLE:   tap_step = m ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_DR: tap_step = m ? TAP_SEL_IR : TAP_CAP_DR;
      TAP_CAP_DR: tap_step = m ? TAP_EX1_DR : TAP_SH_DR;
      TAP_SH_DR:  tap_step = m ? TAP_EX1_DR : TAP_SH_DR;
      TAP_EX1_DR: tap_step = m ? TAP_UPD_DR : TAP_PAU_DR;
      TAP_PAU_DR: tap_step = m ? TAP_EX2_DR : TAP_PAU_DR;
      TAP_EX2_DR: tap_step = m ? TAP_UPD_DR : TAP_SH_DR;
      TAP_UPD_DR: tap_step = m ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_IR: tap_step = m ? TAP_RESET  : TAP_CAP_IR;
      TAP_CAP_IR: tap_step = m ? TAP_EX1_IR : TAP_SH_IR;
      TAP_SH_IR:  tap_step = m ? TAP_EX1_IR : TAP_SH_IR;
      TAP_EX1_IR: tap_step = m ? TAP_UPD_IR : TAP_PAU_IR;
      TAP_PAU_IR: tap_step = m ? TAP_EX2_IR : TAP_PAU_IR;
      TAP_EX2_IR: tap_step = m ? TAP_UPD_IR : TAP_SH_IR;
      TAP_UPD_IR: tap_step = m ? TAP_SEL_DR : TAP_IDLE;
    endcase
  endfunction : tap_step

  assign extest    = (st_reg.ir == `IPMC_IR_EXTEST);
  assign cfg_busy  = (st_reg.cfg == CF_PROG) || (st_reg.cfg == CF_COPY);
  assign clamp_act = cfg_busy && (st_reg.mode == `IPMC_MODE_CLAMP);
  assign setup     = psel && !penable;
  assign wr_en     = psel && penable && pwrite;

  // sequencing, test port, registers
  always_comb
  begin
    st_next          = st_reg;
    st_next.tck_prev = tck_s;

    // test port shifting on test clock rise
    if (rise)
    begin
      st_next.tap = tap_step(st_reg.tap, tms_s);
      unique case (st_reg.tap)
        TAP_RESET:  st_next.ir       = `IPMC_IR_BYPASS;
        TAP_CAP_IR: st_next.ir_shift = `IPMC_IR_CAPTURE;
        TAP_SH_IR:  st_next.ir_shift = {tdi_s, st_reg.ir_shift[3:1]};
        TAP_UPD_IR: st_next.ir       = st_reg.ir_shift;
        TAP_CAP_DR: st_next.bypass   = 1'b0;
        TAP_SH_DR:  st_next.bypass   = tdi_s;
        default:    st_next.bypass   = st_reg.bypass;
      endcase
    end

    // tdo changes on test clock fall
    if (fall)
    begin
      st_next.tdo_en = (st_reg.tap == TAP_SH_IR) || (st_reg.tap == TAP_SH_DR);
      if (st_reg.tap == TAP_SH_IR)
        st_next.tdo = st_reg.ir_shift[0];
      else
        st_next.tdo = bsr_sel ? chain[0] : st_reg.bypass;
    end

    // configuration sequencing
    unique case (st_reg.cfg)
      CF_LOAD:
        if (cfg_load_done)
        begin
          st_next.cfg = CF_WAIT;
          st_next.cnt = '0;
        end
      CF_WAIT:
        if (st_reg.cnt == 16'(`IPMC_PWRUP_CYC - 1))
          st_next.cfg = CF_USER;
        else
          st_next.cnt = st_reg.cnt + 16'h0001;
      CF_USER:
        if (rise && (st_reg.tap == TAP_UPD_IR) && (st_reg.ir_shift == `IPMC_IR_PROGRAM))
        begin
          st_next.mode = st_reg.ctrl_mode;
          st_next.fail = 1'b0;
          st_next.cfg  = (st_reg.ctrl_mode == `IPMC_MODE_BG) ? CF_BGPROG : CF_PROG;
        end
      CF_PROG:
        if (flash_prog_done)
        begin
          st_next.cfg  = flash_prog_ok ? CF_COPY : CF_USER;
          st_next.fail = !flash_prog_ok;
        end
      CF_BGPROG:
        if (flash_prog_done)
        begin
          st_next.cfg     = CF_USER;
          st_next.pending = flash_prog_ok;
          st_next.fail    = !flash_prog_ok;
        end
      CF_COPY:
        if (cfg_load_done)
        begin
          st_next.cfg     = CF_RESET;
          st_next.cnt     = '0;
          st_next.pending = 1'b0;
          st_next.tap     = TAP_RESET;
          st_next.ir      = `IPMC_IR_BYPASS;
        end
      CF_RESET:
        if (st_reg.cnt == 16'(`IPMC_USER_RST_CYC - 1))
          st_next.cfg = CF_USER;
        else
          st_next.cnt = st_reg.cnt + 16'h0001;
    endcase

    // apb: read data and error prepared in setup cycle
    if (setup)
    begin
      st_next.prdata  = '0;
      st_next.pslverr = 1'b0;
      unique case (paddr)
        `IPMC_CTRL_OFF:
          st_next.prdata[`IPMC_CTRL_MODE_MSB:`IPMC_CTRL_MODE_LSB] = st_reg.ctrl_mode;
        `IPMC_STATUS_OFF:
        begin
          st_next.prdata[`IPMC_ST_USER]    = (st_reg.cfg == CF_USER) || (st_reg.cfg == CF_BGPROG);
          st_next.prdata[`IPMC_ST_BUSY]    = (st_reg.cfg == CF_PROG) || (st_reg.cfg == CF_BGPROG);
          st_next.prdata[`IPMC_ST_PENDING] = st_reg.pending;
          st_next.prdata[`IPMC_ST_FAIL]    = st_reg.fail;
          st_next.prdata[`IPMC_ST_COPY]    = (st_reg.cfg == CF_COPY) || (st_reg.cfg == CF_LOAD);
          st_next.prdata[`IPMC_ST_IR_MSB:`IPMC_ST_IR_LSB] = st_reg.ir;
        end
        default:
          st_next.pslverr = 1'b1;
      endcase
    end
    if (wr_en && (paddr == `IPMC_CTRL_OFF))
      st_next.ctrl_mode = pwdata[`IPMC_CTRL_MODE_MSB:`IPMC_CTRL_MODE_LSB];
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_reg           <= '0;
      st_reg.cfg       <= CF_LOAD;
      st_reg.tap       <= TAP_RESET;
      st_reg.ir        <= `IPMC_IR_BYPASS;
      st_reg.ctrl_mode <= `IPMC_CTRL_RESET;
      st_reg.mode      <= `IPMC_MODE_NORMAL;
    end
    else
      st_reg <= st_next;
  end

  // bus answers with no wait state
  assign pready  = 1'b1;
  assign prdata  = st_reg.prdata;
  assign pslverr = st_reg.pslverr;

  assign tdo      = st_reg.tdo;
  assign tdo_oe_n = !st_reg.tdo_en;

  // handshakes to flash controller and loader
  assign flash_prog_req = (st_reg.cfg == CF_PROG) || (st_reg.cfg == CF_BGPROG);
  assign cfg_load_req   = (st_reg.cfg == CF_LOAD) || (st_reg.cfg == CF_COPY);
  assign core_rst_n     = (st_reg.cfg != CF_RESET);
  assign user_mode      = (st_reg.cfg == CF_USER) || (st_reg.cfg == CF_BGPROG);

  // pin control: extest cells, user logic, or tri-state
  always_comb
  begin
    if (extest)
    begin
      pin_out    = cell_data;
      pin_oe_n   = ~cell_en;
      pull_up_en = 1'b0;
    end
    else if (user_mode)
    begin
      pin_out    = core_out;
      pin_oe_n   = core_oe_n;
      pull_up_en = 1'b0;
    end
    else
    begin
      pin_out    = '0;
      pin_oe_n   = '1;
      pull_up_en = !clamp_act;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  chk_copy_after_prog: assert property (
    (st_reg.cfg == CF_PROG) && flash_prog_done && flash_prog_ok |=> cfg_load_req && (st_reg.cfg == CF_COPY))
    else $error("copy did not start after flash programming");

  chk_tristate_prog: assert property (
    cfg_busy && (st_reg.mode == `IPMC_MODE_NORMAL) && !extest |-> (pin_oe_n == '1))
    else $error("pins driven during normal programming");

  chk_reset_after_copy: assert property (
    (st_reg.cfg == CF_COPY) && cfg_load_done |=> (!core_rst_n)[*4] ##1 (core_rst_n && user_mode))
    else $error("self reset after copy wrong");

  chk_bg_pins_live: assert property (
    (st_reg.cfg == CF_BGPROG) && !extest |-> (pin_out == core_out) && (pin_oe_n == core_oe_n))
    else $error("pins not live in background programming");

  chk_bg_no_copy: assert property (
    (st_reg.cfg == CF_BGPROG) && flash_prog_done |=> user_mode && !cfg_load_req ##1 !cfg_load_req)
    else $error("background programming started a copy");

  chk_pwrup_delay: assert property (
    ($past(st_reg.cfg) == CF_WAIT) && (st_reg.cfg == CF_USER) |-> ($past(st_reg.cnt) == 16'(`IPMC_PWRUP_CYC - 1)))
    else $error("user mode entered before power-up delay");

  chk_pullup_normal: assert property (
    (st_reg.cfg == CF_PROG) && (st_reg.mode == `IPMC_MODE_NORMAL) && !extest |-> pull_up_en && !user_mode)
    else $error("pull-up missing in normal programming");

  chk_clamp_nopull: assert property (
    clamp_act |-> !pull_up_en)
    else $error("pull-up on during clamp programming");

  chk_clamp_drive: assert property (
    extest |-> (pin_out == cell_data) && (pin_oe_n == ~cell_en) && !pull_up_en)
    else $error("extest pins differ from held cells");

  chk_clamp_release: assert property (
    clamp_act && (st_reg.cfg == CF_COPY) && cfg_load_done |=> !extest ##4 (pin_oe_n == core_oe_n))
    else $error("clamp not released after programming");
endmodule : ipmc_top

// >>> ipmc_top_bench.sv
// self-checking bench of the programming mode and pin clamp block
// assumes ipmc_pkg, ipmc_top and ipmc_host compiled before it
`include "ipmc_map.svh"
module ipmc_top_bench;
  timeunit 1ns;
  timeprecision 1ns;

  logic        clk, rst_n, psel, penable, pwrite, pready, pslverr, tck, tms, tdi, tdo, tdo_oe_n, e, s;
  logic        flash_prog_req, flash_prog_done, flash_prog_ok, cfg_load_req, cfg_load_done;
  logic        core_rst_n, user_mode, pull_up_en;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] cap, cells;
  logic [7:0]  core_out, core_oe_n, pin_out, pin_oe_n, pin_in;
  int          bad_count, num_checks, cyc, n;

  ipmc_top ipmc_top_i (.clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .tck, .tms, .tdi, .tdo, .tdo_oe_n, .flash_prog_req, .flash_prog_done, .flash_prog_ok, .cfg_load_req,
    .cfg_load_done, .core_rst_n, .user_mode, .core_out, .core_oe_n, .pin_out, .pin_oe_n, .pin_in, .pull_up_en);
  ipmc_host ipmc_host_i (.tck, .tms, .tdi, .tdo, .tdo_oe_n);

  // block clock
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // hang guard
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      bad_count++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : give_verdict

  task automatic check(input logic [47:0] got, input logic [47:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : check

  // one apb transfer: setup, then access until pready
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do
      @(posedge clk);
    while (pready !== 1'b1);
    rd = prdata;
    e  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // one-cycle strobe from the flash controller or the loader
  task automatic pulse(input logic load, input logic ok);
    @(posedge clk);
    flash_prog_done <= !load;
    cfg_load_done   <= load;
    flash_prog_ok   <= ok;
    @(posedge clk);
    flash_prog_done <= 1'b0;
    cfg_load_done   <= 1'b0;
  endtask : pulse

  // cycles until user mode, bounded
  task automatic wait_user(input int lim);
    n = 0;
    while (user_mode !== 1'b1 && n < lim)
    begin
      @(posedge clk);
      n++;
    end
  endtask : wait_user

  task automatic start_prog(input logic [1:0] mode, input logic [3:0] ir);
    apb(1'b1, `IPMC_CTRL_OFF, {30'h0, mode});
    ipmc_host_i.scan(1'b1, 4, {12'h0, ir}, cap);
    check(cap[3:0], 4'h1);
    repeat (5) @(posedge clk);
  endtask : start_prog

  // power cycle: copy first, user mode after the load delay
  task automatic power_up();
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    check({cfg_load_req, user_mode, flash_prog_req, pull_up_en, pin_oe_n}, 12'h9FF);
    pulse(1'b1, 1'b1);
    wait_user(1100);
    check(n > `IPMC_PWRUP_CYC - 3 && n < `IPMC_PWRUP_CYC + 3, 1'b1);
    check({pin_out, pin_oe_n}, {core_out, core_oe_n});
  endtask : power_up

  // reset values, read-only status, unmapped address
  task automatic regs();
    apb(1'b0, `IPMC_CTRL_OFF, 32'h0);
    check({e, rd}, {1'b0, 30'h0, `IPMC_CTRL_RESET});
    apb(1'b1, `IPMC_STATUS_OFF, 32'hFFFFFFFF);
    apb(1'b0, `IPMC_STATUS_OFF, 32'h0);
    check({e, rd[11:0]}, 13'h0F01);
    apb(1'b1, 12'h008, 32'h1);
    check(e, 1'b1);
    apb(1'b0, 12'h008, 32'h0);
    check({e, rd}, {1'b1, 32'h0});
  endtask : regs

  // normal programming: pins tri with pull-up, copy after flash, self reset
  task automatic normal_prog(input logic ok);
    start_prog(`IPMC_MODE_NORMAL, `IPMC_IR_PROGRAM);
    check({flash_prog_req, cfg_load_req, user_mode, pull_up_en, pin_oe_n}, 12'h9FF);
    pulse(1'b0, ok);
    if (!ok)
    begin
      wait_user(20);
      apb(1'b0, `IPMC_STATUS_OFF, 32'h0);
      check({cfg_load_req, rd[3:0]}, 5'h09);
      return;
    end
    repeat (3) @(posedge clk);
    check({cfg_load_req, pull_up_en, pin_oe_n}, 10'h3FF);
    pulse(1'b1, 1'b1);
    n = 0;
    repeat (20)
    begin
      @(posedge clk);
      n += (core_rst_n === 1'b0);
    end
    check(n, `IPMC_USER_RST_CYC);
    check({user_mode, pin_oe_n}, {1'b1, core_oe_n});
  endtask : normal_prog

  // background programming: stays live, no copy until power cycle
  task automatic bg_prog();
    start_prog(`IPMC_MODE_BG, `IPMC_IR_PROGRAM);
    apb(1'b0, `IPMC_STATUS_OFF, 32'h0);
    check(rd[4:0], 5'h03);
    core_out <= 8'hC3;
    repeat (3) @(posedge clk);
    check({flash_prog_req, user_mode, pin_out, pin_oe_n}, {2'b11, 8'hC3, core_oe_n});
    pulse(1'b0, 1'b1);
    n = 0;
    repeat (30)
    begin
      @(posedge clk);
      n += (cfg_load_req !== 1'b0);
    end
    apb(1'b0, `IPMC_STATUS_OFF, 32'h0);
    check({n[4:0], user_mode, rd[2]}, 7'h03);
    power_up();
    apb(1'b0, `IPMC_STATUS_OFF, 32'h0);
    check(rd[2], 1'b0);
  endtask : bg_prog

  // clamp programming: preload, extest holds pins, release after copy
  task automatic clamp_prog();
    start_prog(`IPMC_MODE_CLAMP, `IPMC_IR_SAMPLE);
    ipmc_host_i.scan(1'b0, 16, 16'h0, cap);
    check({cap[6], cap[1]}, {pin_in[3], !core_oe_n[0]});
    s = cap[6];
    cells = {8'h00, 1'b1, s, 6'b001011};
    ipmc_host_i.scan(1'b0, 16, cells, cap);
    start_prog(`IPMC_MODE_CLAMP, `IPMC_IR_PROGRAM);
    check({flash_prog_req, pull_up_en, pin_oe_n}, 10'h2FF);
    start_prog(`IPMC_MODE_CLAMP, `IPMC_IR_EXTEST);
    pin_in <= 8'hA5;
    repeat (3) @(posedge clk);
    check({pull_up_en, pin_oe_n, pin_out[3], pin_out[1:0]}, {1'b0, 8'hF4, s, 2'b01});
    pulse(1'b0, 1'b1);
    repeat (3) @(posedge clk);
    check({cfg_load_req, pull_up_en, pin_oe_n}, 10'h2F4);
    apb(1'b0, `IPMC_STATUS_OFF, 32'h0);
    check({rd[11:8], rd[4:0]}, 9'h010);
    pulse(1'b1, 1'b1);
    wait_user(30);
    apb(1'b0, `IPMC_STATUS_OFF, 32'h0);
    check({pin_out, pin_oe_n, rd[11:8]}, {core_out, core_oe_n, 4'hF});
  endtask : clamp_prog

  // main sequence
  initial
  begin
    {rst_n, psel, penable, pwrite, flash_prog_done, flash_prog_ok, cfg_load_done} = 7'h00;
    paddr      = 12'h000;
    pwdata     = 32'h0;
    core_out   = 8'h3C;
    core_oe_n  = 8'h0F;
    pin_in     = 8'h5A;
    bad_count  = 0;
    num_checks = 0;
    cyc        = 0;
    power_up();
    regs();
    normal_prog(1'b0);
    normal_prog(1'b1);
    bg_prog();
    clamp_prog();
    give_verdict();
  end
endmodule : ipmc_top_bench
